// file: rtl/usart_regs.svh
// constants for the serial transceiver: counts, field limits and reset values
`ifndef USART_REGS_SVH
`define USART_REGS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ        40000000
`define OS_LAST       4'hF
`define OS_MID        4'h9
`define IR_MAX_BAUD   115200
`define IR_316_TICKS  8'h03
`define IR_BIT_TICKS  5'h10

// ****************************************************************
// frame format and storage
// ****************************************************************
`define NBITS_BASE    4'h4
`define SPI_LAST      4'h7
`define CHAR_MAX      3'h4
`define FIFO_DEPTH    16
`define NCO_W         16
`define LINE_IDLE     1'b1

`endif

// file: rtl/usart_pkg.sv
// types shared by the serial transceiver and its helpers
`default_nettype none
package usart_pkg;

    typedef enum logic [1:0] {MODE_ASYNC, MODE_SYNC_MASTER, MODE_SYNC_SLAVE, MODE_SPI} mode_t;
    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;
    typedef enum logic [1:0] {IR_316, IR_FIXED, IR_OFF} ir_mode_t;

    // static configuration, held by software
    typedef struct packed {
        mode_t       mode;
        logic [2:0]  char_sel;   // 0..4 selects 5..9 data bits
        logic        stop2;
        parity_t     parity;
        logic        mpcm;
        logic        msb_first;  // master SPI only
        logic [15:0] baud_inc;   // phase step of the fractional generator
        logic        ir_en;
        ir_mode_t    ir_mode;
        logic [7:0]  ir_width;
    } cfg_t;

    // one received frame as it waits in the receive buffer
    typedef struct packed {
        logic       perr;
        logic       ferr;
        logic [8:0] data;
    } rx_word_t;

endpackage : usart_pkg
`default_nettype wire

// file: rtl/sync_fifo.sv
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    localparam logic [AW-1:0] LASTP = AW'(D - 1);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    // honest full and empty from the fill count
    assign in_ready  = cnt_q != FULL;
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        wp_d  = push ? ((wp_q == LASTP) ? '0 : wp_q + 1'b1) : wp_q;
        rp_d  = pop ? ((rp_q == LASTP) ? '0 : rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            if (push) begin
                mem_q[wp_q] <= in_data;
            end
        end
    end
endmodule : sync_fifo
`default_nettype wire

// file: rtl/ir_pulse_codec.sv
// infrared pulse modulator and demodulator for one serial line
`timescale 1ns/1ps
`default_nettype none
module ir_pulse_codec
    import usart_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       enable,
    input  wire ir_mode_t   mode,
    input  wire logic [7:0] width,
    input  wire logic       os_tick,
    input  wire logic       bit_start,
    input  wire logic       tx_line,
    input  wire logic       ir_rx,
    output logic            ir_tx,
    output logic            rx_line
);
`include "usart_regs.svh"

    logic       bs_q, bs_d;
    logic [7:0] pl_q, pl_d;
    logic [1:0] rf_q, rf_d;
    logic [4:0] rl_q, rl_d;

    // pulse timers; 3/16 counts oversample ticks, fixed counts clocks
    always_comb begin
        bs_d = bit_start;
        rf_d = {rf_q[0], ir_rx};
        pl_d = pl_q;
        rl_d = rl_q;
        if (bs_q && !tx_line && mode != IR_OFF) begin
            pl_d = (mode == IR_316) ? `IR_316_TICKS : width;
        end else if (pl_q != 8'h00 && (mode == IR_FIXED || os_tick)) begin
            pl_d = pl_q - 8'h01;
        end
        // two samples high before a pulse counts: spikes are dropped
        if (rf_q == 2'b11) begin
            rl_d = `IR_BIT_TICKS;
        end else if (rl_q != 5'h00 && os_tick) begin
            rl_d = rl_q - 5'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bs_q <= 1'b0;
            pl_q <= 8'h00;
            rf_q <= 2'b00;
            rl_q <= 5'h00;
        end else if (clk_en) begin
            bs_q <= bs_d;
            pl_q <= pl_d;
            rf_q <= rf_d;
            rl_q <= rl_d;
        end
    end

    // modulation off passes the line through inverted, emitter active high
    assign ir_tx   = !enable ? 1'b0 : (mode == IR_OFF) ? !tx_line : (pl_q != 8'h00);
    assign rx_line = (mode == IR_OFF) ? !rf_q[0] : (rl_q == 5'h00);
endmodule : ir_pulse_codec
`default_nettype wire

// file: rtl/usart_core.sv
// serial transceiver: async, sync master/slave and master SPI with buffered paths
`timescale 1ns/1ps
`default_nettype none
module usart_core
    import usart_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire cfg_t       cfg,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [8:0] tx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output rx_word_t        rx_word,
    input  wire logic       rxc_en,
    input  wire logic       txc_en,
    input  wire logic       dre_en,
    output logic            rxc_event,
    output logic            txc_event,
    output logic            dre_event,
    input  wire logic       txc_clr,
    output logic            overrun,
    input  wire logic       ovr_clr,
    output logic            txd,
    input  wire logic       rxd,
    output logic            xck_o,
    output logic            xck_oe_n,
    input  wire logic       xck_i,
    output logic            ir_tx,
    input  wire logic       ir_rx
);
`include "usart_regs.svh"

    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ser_st_t;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction : rev8

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction : maj3

    logic       is_async, is_spi, is_master;
    logic [3:0] nbits_m1;
    logic [8:0] dmask;
    logic       par_on, par_odd;

    // format decode; SPI ignores the async-only settings
    assign is_async  = cfg.mode == MODE_ASYNC;
    assign is_spi    = cfg.mode == MODE_SPI;
    assign is_master = cfg.mode == MODE_SYNC_MASTER || is_spi;
    assign nbits_m1  = is_spi ? `SPI_LAST : 4'(cfg.char_sel) + `NBITS_BASE;
    assign dmask     = 9'h1FF >> (`CHAR_MAX - cfg.char_sel);
    assign par_on    = cfg.parity != PAR_NONE && !is_spi;
    assign par_odd   = cfg.parity == PAR_ODD;

    // ****************************************************************
    // baud generator and serial clock
    // ****************************************************************
    logic [15:0] acc_q, acc_d;
    logic [16:0] acc_sum;
    logic        tick, xck_q, xck_d, xs_q, xs_d, xsp_q, xsp_d;
    logic        rise, fall, tx_busy;

    // phase accumulator: the carry is the tick, at baud_inc/65536 of clk_sys
    assign acc_sum = {1'b0, acc_q} + {1'b0, cfg.baud_inc};
    assign tick    = acc_sum[16];

    always_comb begin
        acc_d = acc_sum[15:0];
        xs_d  = xck_i;
        xsp_d = xs_q;
        // master clock toggles once per tick: never above clk_sys/2
        if (!is_master || !tx_busy) begin
            xck_d = 1'b0;
        end else begin
            xck_d = tick ? !xck_q : xck_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_q <= 16'h0000;
            xck_q <= 1'b0;
            xs_q  <= 1'b0;
            xsp_q <= 1'b0;
        end else if (clk_en) begin
            acc_q <= acc_d;
            xck_q <= xck_d;
            xs_q  <= xs_d;
            xsp_q <= xsp_d;
        end
    end

    // slave edges come from the partner's clock
    assign rise = is_master ? (tick && tx_busy && !xck_q) : (xs_q && !xsp_q);
    assign fall = is_master ? (tick && tx_busy && xck_q) : (!xs_q && xsp_q);
    assign xck_o    = xck_q;
    assign xck_oe_n = !is_master;

    // ****************************************************************
    // transmit buffer and shifter
    // ****************************************************************
    logic       txf_valid, txf_ready;
    logic [8:0] txf_data;
    ser_st_t    tx_st_q, tx_st_d;
    logic [8:0] tx_sh_q, tx_sh_d, ld_data;
    logic [3:0] tx_cnt_q, tx_cnt_d, tx_os_q, tx_os_d;
    logic       tx_par_q, tx_par_d, txd_q, txd_d, tx_two_q, tx_two_d;
    logic       tx_step, tx_fin, tx_pop, tx_done, tx_bit0;

    sync_fifo #(.W(9), .D(`FIFO_DEPTH)) u_tx_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .in_valid  (tx_valid),
        .in_ready  (txf_ready),
        .in_data   (tx_data),
        .out_valid (txf_valid),
        .out_ready (tx_pop),
        .out_data  (txf_data)
    );

    assign tx_ready = txf_ready;
    assign tx_busy  = tx_st_q != ST_IDLE;
    // async bit lasts 16 ticks: bit rate at most clk_sys/16
    assign tx_step  = is_async ? (tick && tx_os_q == `OS_LAST) : fall;
    assign ld_data  = (is_spi && cfg.msb_first) ? {1'b0, rev8(txf_data[7:0])}
                                               : (txf_data & dmask);

    // frame sequencer; a finished frame reloads at once if data waits
    always_comb begin
        tx_st_d  = tx_st_q;
        tx_sh_d  = tx_sh_q;
        tx_cnt_d = tx_cnt_q;
        tx_os_d  = (tx_busy && tick) ? tx_os_q + 4'h1 : tx_os_q;
        tx_par_d = tx_par_q;
        txd_d    = txd_q;
        tx_two_d = tx_two_q;
        tx_fin   = 1'b0;
        tx_pop   = 1'b0;
        tx_done  = 1'b0;
        tx_bit0  = 1'b0;
        if (tx_step) begin
            tx_bit0 = tx_busy;
            unique case (tx_st_q)
                ST_IDLE: ;
                ST_START: begin
                    txd_d    = tx_sh_q[0];
                    tx_sh_d  = tx_sh_q >> 1;
                    tx_cnt_d = 4'h0;
                    tx_st_d  = ST_DATA;
                end
                ST_DATA: begin
                    if (tx_cnt_q != nbits_m1) begin
                        tx_cnt_d = tx_cnt_q + 4'h1;
                        txd_d    = tx_sh_q[0];
                        tx_sh_d  = tx_sh_q >> 1;
                    end else if (is_spi) begin
                        tx_fin = 1'b1;
                    end else if (par_on) begin
                        txd_d   = tx_par_q;
                        tx_st_d = ST_PAR;
                    end else begin
                        txd_d    = `LINE_IDLE;
                        tx_two_d = 1'b0;
                        tx_st_d  = ST_STOP;
                    end
                end
                ST_PAR: begin
                    txd_d    = `LINE_IDLE;
                    tx_two_d = 1'b0;
                    tx_st_d  = ST_STOP;
                end
                ST_STOP: begin
                    if (cfg.stop2 && !tx_two_q) begin
                        tx_two_d = 1'b1;
                    end else begin
                        tx_fin = 1'b1;
                    end
                end
            endcase
        end
        if (tx_fin || !tx_busy) begin
            if (txf_valid) begin
                // reload in the same cycle: no gap between frames
                tx_pop   = 1'b1;
                tx_bit0  = 1'b1;
                tx_os_d  = 4'h0;
                tx_cnt_d = 4'h0;
                tx_par_d = (^ld_data) ^ par_odd;
                if (is_spi) begin
                    txd_d   = ld_data[0];
                    tx_sh_d = ld_data >> 1;
                    tx_st_d = ST_DATA;
                end else begin
                    txd_d   = 1'b0;
                    tx_sh_d = ld_data;
                    tx_st_d = ST_START;
                end
            end else begin
                txd_d   = `LINE_IDLE;
                tx_st_d = ST_IDLE;
                tx_done = tx_busy;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_st_q  <= ST_IDLE;
            tx_sh_q  <= 9'h000;
            tx_cnt_q <= 4'h0;
            tx_os_q  <= 4'h0;
            tx_par_q <= 1'b0;
            txd_q    <= `LINE_IDLE;
            tx_two_q <= 1'b0;
        end else if (clk_en) begin
            tx_st_q  <= tx_st_d;
            tx_sh_q  <= tx_sh_d;
            tx_cnt_q <= tx_cnt_d;
            tx_os_q  <= tx_os_d;
            tx_par_q <= tx_par_d;
            txd_q    <= txd_d;
            tx_two_q <= tx_two_d;
        end
    end

    assign txd = txd_q;

    // ****************************************************************
    // infrared codec
    // ****************************************************************
    logic ir_line, rx_src;

    ir_pulse_codec u_ir (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .enable    (cfg.ir_en),
        .mode      (cfg.ir_mode),
        .width     (cfg.ir_width),
        .os_tick   (tick),
        .bit_start (tx_bit0),
        .tx_line   (txd_q),
        .ir_rx     (ir_rx),
        .ir_tx     (ir_tx),
        .rx_line   (ir_line)
    );

    // only this instance can take the codec
    assign rx_src = cfg.ir_en ? ir_line : rxd;

    // ****************************************************************
    // receive shifter and buffer
    // ****************************************************************
    ser_st_t    rx_st_q, rx_st_d;
    logic [2:0] rx_h_q, rx_h_d, rx_v_q, rx_v_d;
    logic [3:0] rx_os_q, rx_os_d, rx_cnt_q, rx_cnt_d;
    logic [8:0] rx_sh_q, rx_sh_d;
    logic       rx_par_q, rx_par_d, rx_perr_q, rx_perr_d, rxp_q, rxp_d;
    logic       rxf, bit_ev, bit_val, rx_end, rx_ferr, rx_push, accept;
    logic       rxf_ready, ovr_q, ovr_d, txc_q, txc_d;
    rx_word_t   rx_new;

    // three-sample majority is the low-pass filter
    assign rxf     = maj3(rx_h_q);
    assign bit_ev  = is_async ? (tick && rx_os_q == `OS_MID) : rise;
    assign bit_val = is_async ? maj3({rx_v_q[1:0], rxf}) : rx_h_q[0];

    always_comb begin
        rx_st_d   = rx_st_q;
        rx_h_d    = {rx_h_q[1:0], rx_src};
        rx_v_d    = tick ? {rx_v_q[1:0], rxf} : rx_v_q;
        rx_os_d   = tick ? rx_os_q + 4'h1 : rx_os_q;
        rxp_d     = rxf;
        rx_cnt_d  = rx_cnt_q;
        rx_sh_d   = rx_sh_q;
        rx_par_d  = rx_par_q;
        rx_perr_d = rx_perr_q;
        rx_end    = 1'b0;
        rx_ferr   = 1'b0;
        unique case (rx_st_q)
            ST_IDLE: begin
                rx_cnt_d  = 4'h0;
                rx_par_d  = 1'b0;
                rx_perr_d = 1'b0;
                if (is_async && rxp_q && !rxf) begin
                    rx_os_d = 4'h0;
                    rx_st_d = ST_START;
                end else if (is_spi && tx_busy) begin
                    rx_st_d = ST_DATA;
                end else if (!is_async && !is_spi && rise && !bit_val) begin
                    rx_st_d = ST_DATA;
                end
            end
            ST_START: if (bit_ev) begin
                // still high at mid-bit: a spike, not a start
                rx_st_d = bit_val ? ST_IDLE : ST_DATA;
            end
            ST_DATA: if (bit_ev) begin
                rx_sh_d  = {bit_val, rx_sh_q[8:1]};
                rx_par_d = rx_par_q ^ bit_val;
                rx_cnt_d = rx_cnt_q + 4'h1;
                if (rx_cnt_q == nbits_m1) begin
                    rx_end  = is_spi;
                    rx_st_d = is_spi ? ST_IDLE : (par_on ? ST_PAR : ST_STOP);
                end
            end
            ST_PAR: if (bit_ev) begin
                rx_perr_d = bit_val != (rx_par_q ^ par_odd);
                rx_st_d   = ST_STOP;
            end
            ST_STOP: if (bit_ev) begin
                // the second stop bit is not checked, idle time is legal
                rx_ferr = !bit_val;
                rx_end  = 1'b1;
                rx_st_d = ST_IDLE;
            end
        endcase
    end

    // right-align the shifted bits; SPI msb-first is turned back round
    always_comb begin
        rx_new.ferr = rx_ferr;
        rx_new.perr = rx_perr_q;
        rx_new.data = rx_sh_d >> (`SPI_LAST + 4'h1 - nbits_m1);
        if (is_spi && cfg.msb_first) begin
            rx_new.data = {1'b0, rev8(rx_new.data[7:0])};
        end
        // a data frame (top bit low) is dropped until software clears mpcm
        accept  = !(cfg.mpcm && !is_spi && !rx_new.data[nbits_m1]);
        rx_push = rx_end && accept;
        ovr_d   = (ovr_q && !ovr_clr) || (rx_push && !rxf_ready);
        txc_d   = (txc_q && !txc_clr) || tx_done;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_st_q   <= ST_IDLE;
            rx_h_q    <= 3'b111;
            rx_v_q    <= 3'b111;
            rx_os_q   <= 4'h0;
            rxp_q     <= 1'b1;
            rx_cnt_q  <= 4'h0;
            rx_sh_q   <= 9'h000;
            rx_par_q  <= 1'b0;
            rx_perr_q <= 1'b0;
            ovr_q     <= 1'b0;
            txc_q     <= 1'b0;
        end else if (clk_en) begin
            rx_st_q   <= rx_st_d;
            rx_h_q    <= rx_h_d;
            rx_v_q    <= rx_v_d;
            rx_os_q   <= rx_os_d;
            rxp_q     <= rxp_d;
            rx_cnt_q  <= rx_cnt_d;
            rx_sh_q   <= rx_sh_d;
            rx_par_q  <= rx_par_d;
            rx_perr_q <= rx_perr_d;
            ovr_q     <= ovr_d;
            txc_q     <= txc_d;
        end
    end

    // a full buffer loses the new frame, never an old one
    sync_fifo #(.W(11), .D(`FIFO_DEPTH)) u_rx_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .in_valid  (rx_push),
        .in_ready  (rxf_ready),
        .in_data   (rx_new),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_word)
    );

    // ****************************************************************
    // event outputs
    // ****************************************************************
    assign rxc_event = rxc_en && rx_valid;
    assign txc_event = txc_en && txc_q;
    assign dre_event = dre_en && txf_ready;
    assign overrun   = ovr_q;
endmodule : usart_core
`default_nettype wire

// file: testbench/usart_chk.sv
// port assertions for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module usart_chk
    import usart_pkg::*;
(
    input wire logic     clk_sys,
    input wire logic     rst_n,
    input wire cfg_t     cfg,
    input wire logic     rx_valid,
    input wire logic     rx_ready,
    input wire rx_word_t rx_word,
    input wire logic     rxc_en,
    input wire logic     rxc_event,
    input wire logic     tx_ready,
    input wire logic     dre_en,
    input wire logic     dre_event,
    input wire logic     txc_en,
    input wire logic     txc_event,
    input wire logic     overrun,
    input wire logic     ovr_clr,
    input wire logic     txd,
    input wire logic     xck_oe_n,
    input wire logic     ir_tx
);
    // ****
    // properties
    // ****
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // any async bit is at least 16 clocks, so a low level outlasts 8
    sequence fall_async_s;
        cfg.mode == MODE_ASYNC && $fell(txd);
    endsequence
    sequence low_held_s;
        (!txd)[*8];
    endsequence
    chk_rxc_event_gate: assert property (rxc_event == (rxc_en && rx_valid))
        else $error("receive event not gated by its enable");
    chk_dre_event_gate: assert property (dre_event == (dre_en && tx_ready))
        else $error("empty event not gated by its enable");
    chk_txc_masked: assert property (!txc_en |-> !txc_event)
        else $error("transmit event seen while disabled");
    chk_ovr_sticky: assert property (overrun && !ovr_clr |=> overrun)
        else $error("overrun flag dropped without clear");
    chk_rx_word_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
        else $error("receive word changed before pop");
    chk_bit_low_len: assert property (fall_async_s |-> low_held_s)
        else $error("low bit on line too short");
    chk_xck_released: assert property (cfg.mode == MODE_ASYNC |-> xck_oe_n)
        else $error("clock pin driven in async mode");
    chk_ir_quiet: assert property (!cfg.ir_en |-> !ir_tx)
        else $error("infrared output active while off");
endmodule : usart_chk
bind usart_core usart_chk u_usart_chk (.clk_sys, .rst_n, .cfg, .rx_valid, .rx_ready, .rx_word,
    .rxc_en, .rxc_event, .tx_ready, .dre_en, .dre_event, .txc_en, .txc_event, .overrun,
    .ovr_clr, .txd, .xck_oe_n, .ir_tx);
`default_nettype wire

// file: testbench/uart_partner.sv
// remote async partner: drives rxd and decodes txd
`timescale 1ns/1ps
`default_nettype none
module uart_partner #(
    parameter int BIT = 32
) (
    input  wire logic clk_sys,
    input  wire logic txd,
    output var logic  rxd
);
    // line idles high between frames
    initial rxd = 1'b1;
    // start low, data lsb first, parity, one stop
    task automatic send(input logic [7:0] d, input logic p, input logic stp);
        logic [10:0] f;
        f = {stp, p, d, 1'b0};
        @(posedge clk_sys);
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge clk_sys);
        end
        rxd <= 1'b1;
    endtask : send
    // waits for a start edge, samples mid-bit; w is -1 on timeout
    task automatic recv(output logic [10:0] f, output int w);
        w = 0;
        while (txd !== 1'b0 && w < 2000) begin
            @(posedge clk_sys);
            w++;
        end
        if (w == 2000) w = -1;
        repeat (BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd;
            if (i < 10) repeat (BIT) @(posedge clk_sys);
        end
    endtask : recv
endmodule : uart_partner
`default_nettype wire

// file: testbench/tb_usart_with_ir_pulse_codec.sv
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module tb_usart_with_ir_pulse_codec
    import usart_pkg::*;
;
    logic       clk_sys, rst_n, tx_valid, tx_ready, rx_valid, rx_ready, ev_en, txc_clr;
    logic       rxc_event, txc_event, dre_event, overrun, txd, rxd, xck_o, xck_oe_n, ir_tx;
    logic       ovr_clr;
    logic [8:0] tx_data;
    cfg_t       cfg;
    rx_word_t   rx_word;
    int         error_cnt = 0;
    int         total_checks = 0;
    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    usart_core u_usart_core (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .cfg(cfg),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_word(rx_word), .rxc_en(ev_en), .txc_en(ev_en), .dre_en(ev_en),
        .rxc_event(rxc_event), .txc_event(txc_event), .dre_event(dre_event), .txc_clr(txc_clr),
        .overrun(overrun), .ovr_clr(ovr_clr), .txd(txd), .rxd(rxd), .xck_o(xck_o),
        .xck_oe_n(xck_oe_n), .xck_i(1'b0), .ir_tx(ir_tx), .ir_rx(1'b0));
    uart_partner u_uart_partner (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
    // ****
    // helpers
    // ****
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // bounded wait for a received word, then pop it
    task automatic get_rx(input logic [10:0] exp);
        int n;
        // look only at settled outputs, never at the pop edge itself
        @(negedge clk_sys);
        for (n = 0; n < 1000 && rx_valid !== 1'b1; n++) @(negedge clk_sys);
        if (n == 1000) begin
            check(11'h7FF, 11'h000);
            conclude();
        end else begin
            check(rx_word, exp);
            @(posedge clk_sys) rx_ready <= 1'b1;
            @(posedge clk_sys) rx_ready <= 1'b0;
        end
    endtask : get_rx
    // two words back to back, then transmit-complete event and its clear
    task automatic test_tx();
        logic [10:0] f;
        int w;
        @(posedge clk_sys) tx_valid <= 1'b1;
        tx_data <= 9'h0A7;
        @(posedge clk_sys) tx_data <= 9'h03C;
        @(posedge clk_sys) tx_valid <= 1'b0;
        u_uart_partner.recv(f, w);
        check(f, {1'b1, 1'b1, 8'hA7, 1'b0});
        u_uart_partner.recv(f, w);
        check(f, {1'b1, 1'b0, 8'h3C, 1'b0});
        check({10'h0, w >= 0 && w < 20}, 11'h001);
        repeat (40) @(negedge clk_sys);
        check({10'h0, txc_event}, 11'h001);
        @(posedge clk_sys) txc_clr <= 1'b1;
        @(posedge clk_sys) txc_clr <= 1'b0;
        @(negedge clk_sys);
        check({10'h0, txc_event}, 11'h000);
        $display("test_tx done");
    endtask : test_tx
    // good frame, then bad parity with bad stop
    task automatic test_rx();
        u_uart_partner.send(8'hC3, 1'b0, 1'b1);
        get_rx({2'b00, 9'h0C3});
        u_uart_partner.send(8'hC3, 1'b1, 1'b0);
        get_rx({2'b11, 9'h0C3});
        $display("test_rx done");
    endtask : test_rx
    // unaddressed frames dropped until the top bit marks an address
    task automatic test_mpcm();
        @(posedge clk_sys) cfg.mpcm <= 1'b1;
        u_uart_partner.send(8'h41, 1'b0, 1'b1);
        repeat (100) @(negedge clk_sys);
        check({10'h0, rx_valid}, 11'h000);
        u_uart_partner.send(8'h81, 1'b0, 1'b1);
        get_rx({2'b00, 9'h081});
        $display("test_mpcm done");
    endtask : test_mpcm
    // seventeen frames into sixteen words: the newest is lost, overrun sticks
    task automatic test_ovr();
        repeat (17) u_uart_partner.send(8'h81, 1'b0, 1'b1);
        check({10'h0, overrun}, 11'h001);
        repeat (16) get_rx({2'b00, 9'h081});
        @(negedge clk_sys);
        check({10'h0, rx_valid}, 11'h000);
        @(posedge clk_sys) ovr_clr <= 1'b1;
        @(posedge clk_sys) ovr_clr <= 1'b0;
        @(negedge clk_sys);
        check({10'h0, overrun}, 11'h000);
        $display("test_ovr done");
    endtask : test_ovr
    // reset, then the scenarios; 8 data bits, even parity, 32 clocks a bit
    initial begin
        rst_n = 1'b0;
        tx_valid = 1'b0;
        tx_data = 9'h000;
        rx_ready = 1'b0;
        ev_en = 1'b1;
        txc_clr = 1'b0;
        ovr_clr = 1'b0;
        cfg = '0;
        cfg.char_sel = 3'h3;
        cfg.parity = PAR_EVEN;
        cfg.baud_inc = 16'h8000;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check({5'h00, overrun, xck_o, xck_oe_n, txd, tx_ready, rx_valid}, 11'h00E);
        test_tx();
        test_rx();
        test_mpcm();
        test_ovr();
        conclude();
    end
endmodule : tb_usart_with_ir_pulse_codec
`default_nettype wire
